//--- pim_regs.svh
// register offsets, field positions and timing constants of the pin block
`ifndef PIM_REGS_SVH
`define PIM_REGS_SVH

`define PIM_OFS_IRQ_ENABLE 12'h05C
`define PIM_OFS_INDICATOR_CFG 12'h1BC
`define PIM_OFS_PIN_CFG 12'h1E0
`define PIM_OFS_IRQ_STS_EN 12'h1E8
`define PIM_OFS_QUALIFY 12'h1F0

`define PIM_PINS 6
`define PIM_GLOBAL_EN_BIT 12
`define PIM_STS_LSB 0
`define PIM_EN_LSB 16
`define PIM_FUN_LSB 8
`define PIM_SEL_LSB 0
`define PIM_TRIG_POL_LSB 16
`define PIM_BUF_LSB 0
`define PIM_QUAL_LSB 0

`define PIM_FUN_PUSH_PULL 2'h3
`define PIM_RST_SIX 6'h00
`define PIM_RST_WORD 32'h00000000
`define PIM_LED_MAP_DEFAULT 8'hE4

`define PIM_CLK_PERIOD_NS 25
`define PIM_MIN_ACTIVE_NS 40
`define PIM_QUAL_CYCLES \
  ((`PIM_MIN_ACTIVE_NS + `PIM_CLK_PERIOD_NS - 1) / `PIM_CLK_PERIOD_NS)

`endif

//--- pim_pkg.sv
// types shared by the pin interrupt and indicator block
package pim_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pim_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pim_apb_rsp_type;

  typedef struct packed {
    logic [5:0] led_pol;
    logic [1:0] func;
    logic [5:0] sel;
  } pim_strap_type;

  typedef struct packed {
    logic load;
    logic [1:0] func;
    logic [5:0] sel;
  } pim_eeprom_type;

  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] pullup_en;
    logic [5:0] inbuf_en;
  } pim_pad_type;

  typedef logic [3:0][5:0] pim_led_src_type;
endpackage

//--- pim_sync.sv
// three-stage synchroniser; a bit changes once stages two and three agree
module pim_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk)
  begin
    s1_q <= d;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // a single disagreeing sample is ignored as a glitch
      always_ff @(posedge clk)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule

//--- pim_qual.sv
// per-pin level qualifier: counts consecutive cycles at trigger level
module pim_qual (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] level,
  input wire logic [7:0] limit,
  output logic [5:0] hit
);
  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_pin
      logic [7:0] cnt_q;
      logic [7:0] cnt_d;
      assign cnt_d = !level[i] ? 8'h00 :
                     (cnt_q >= limit) ? cnt_q : cnt_q + 8'h01;
      // hit once the level has been seen for limit cycles in a row
      assign hit[i] = level[i] &
                      (({1'b0, cnt_q} + 9'h001) >= {1'b0, limit});
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          cnt_q <= 8'h00;
        end
        else
        begin
          cnt_q <= cnt_d;
        end
      end
    end
  endgenerate
endmodule

//--- pim_top.sv
// pin interrupt capture and indicator/general-purpose pin selection
//
// The APB slave port is this design's own decision.
`include "pim_regs.svh"

module pim_top #(
  parameter logic [7:0] LED_SRC_MAP = `PIM_LED_MAP_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire pim_pkg::pim_apb_req_type apb_req,
  output pim_pkg::pim_apb_rsp_type apb_rsp,
  input wire logic [5:0] pin_in,
  input wire pim_pkg::pim_strap_type strap,
  input wire pim_pkg::pim_eeprom_type eeprom,
  input wire logic [5:0] gp_data_out,
  input wire logic [5:0] gp_dir_out,
  input wire pim_pkg::pim_led_src_type led_source,
  output pim_pkg::pim_pad_type pad,
  output logic system_irq_status,
  output logic irq
);
  import pim_pkg::*;

  localparam logic [7:0] QUAL_RESET = 8'(`PIM_QUAL_CYCLES);

  logic [5:0] pin_sync;
  logic [13:0] strap_sync;
  logic [5:0] qual_hit;

  logic global_en_q;
  logic [1:0] indicator_function_sel_q;
  logic [5:0] indicator_select_q;
  logic [5:0] led_pol_q;
  logic [5:0] pin_trigger_polarity_q;
  logic [5:0] buf_push_pull_q;
  logic [5:0] sts_q;
  logic [5:0] sts_d;
  logic [5:0] en_q;
  logic [7:0] qual_limit_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic event_q;
  pim_pad_type pad_q;
  pim_pad_type pad_d;

  // bus decode
  wire setup = apb_req.psel & ~apb_req.penable;
  wire access = apb_req.psel & apb_req.penable;
  wire wr = access & apb_req.pwrite;
  wire hit_ien = apb_req.paddr == `PIM_OFS_IRQ_ENABLE;
  wire hit_cfg = apb_req.paddr == `PIM_OFS_INDICATOR_CFG;
  wire hit_pcfg = apb_req.paddr == `PIM_OFS_PIN_CFG;
  wire hit_sts = apb_req.paddr == `PIM_OFS_IRQ_STS_EN;
  wire hit_qual = apb_req.paddr == `PIM_OFS_QUALIFY;
  wire hit_any = hit_ien | hit_cfg | hit_pcfg | hit_sts | hit_qual;
  wire wr_ien = wr & hit_ien;
  wire wr_cfg = wr & hit_cfg;
  wire wr_pcfg = wr & hit_pcfg;
  wire wr_sts = wr & hit_sts;
  wire wr_qual = wr & hit_qual;
  wire [31:0] wd = apb_req.pwdata;

  // reserved bits are never stored, so they read back zero
  wire [31:0] rd_ien = {19'h00000, global_en_q, 12'h000};
  wire [31:0] rd_cfg = {22'h000000, indicator_function_sel_q, 2'h0,
                        indicator_select_q};
  wire [31:0] rd_pcfg = {10'h000, pin_trigger_polarity_q, 10'h000,
                         buf_push_pull_q};
  wire [31:0] rd_sts = {10'h000, en_q, 10'h000, sts_q};
  wire [31:0] rd_qual = {24'h000000, qual_limit_q};
  wire [31:0] rd_word = hit_ien ? rd_ien :
                        hit_cfg ? rd_cfg :
                        hit_pcfg ? rd_pcfg :
                        hit_sts ? rd_sts :
                        hit_qual ? rd_qual : `PIM_RST_WORD;

  assign apb_rsp = '{prdata: prdata_q,
                     pready: 1'b1,
                     pslverr: access & ~hit_any};

  // pins and straps come from outside the clock domain
  pim_sync #(.WIDTH(6)) u_pin_sync (
    .clk(clk),
    .d(pin_in),
    .q(pin_sync)
  );
  pim_sync #(.WIDTH(14)) u_strap_sync (
    .clk(clk),
    .d(strap),
    .q(strap_sync)
  );
  wire [5:0] strap_pol = strap_sync[13:8];
  wire [1:0] strap_fun = strap_sync[7:6];
  wire [5:0] strap_sel = strap_sync[5:0];

  // trigger level per pin; input buffer is off for indicator pins
  wire [5:0] trig_level = ~(pin_sync ^ pin_trigger_polarity_q) &
                          ~indicator_select_q;

  pim_qual u_qual (
    .clk(clk),
    .rst(rst),
    .level(trig_level),
    .limit(qual_limit_q),
    .hit(qual_hit)
  );

  // set wins over the clearing write
  wire [5:0] clr_mask = wr_sts ? wd[5:0] : `PIM_RST_SIX;
  assign sts_d = (sts_q & ~clr_mask) | qual_hit;
  wire pin_event = |(sts_q & en_q);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sts_q <= `PIM_RST_SIX;
      en_q <= `PIM_RST_SIX;
      global_en_q <= 1'b0;
      pin_trigger_polarity_q <= `PIM_RST_SIX;
      buf_push_pull_q <= `PIM_RST_SIX;
      qual_limit_q <= QUAL_RESET;
      event_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      sts_q <= sts_d;
      if (wr_sts)
      begin
        en_q <= wd[`PIM_EN_LSB +: 6];
      end
      if (wr_ien)
      begin
        global_en_q <= wd[`PIM_GLOBAL_EN_BIT];
      end
      if (wr_pcfg)
      begin
        pin_trigger_polarity_q <= wd[`PIM_TRIG_POL_LSB +: 6];
        buf_push_pull_q <= wd[`PIM_BUF_LSB +: 6];
      end
      if (wr_qual)
      begin
        qual_limit_q <= wd[`PIM_QUAL_LSB +: 8];
      end
      event_q <= pin_event;
      irq_q <= pin_event & global_en_q;
    end
  end

  // straps load while reset is held; the eeprom may override later
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      indicator_function_sel_q <= strap_fun;
      indicator_select_q <= strap_sel;
      led_pol_q <= strap_pol;
    end
    else if (eeprom.load)
    begin
      indicator_function_sel_q <= eeprom.func;
      indicator_select_q <= eeprom.sel;
    end
    else if (wr_cfg)
    begin
      indicator_function_sel_q <= wd[`PIM_FUN_LSB +: 2];
      indicator_select_q <= wd[`PIM_SEL_LSB +: 6];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_q <= `PIM_RST_WORD;
    end
    else if (setup & ~apb_req.pwrite)
    begin
      prdata_q <= rd_word;
    end
  end

  // function code to activity source, table held in a parameter
  wire [1:0] src_sel = LED_SRC_MAP[{indicator_function_sel_q, 1'b0} +: 2];
  wire [5:0] led_act = led_source[src_sel];
  wire led_push_pull = indicator_function_sel_q == `PIM_FUN_PUSH_PULL;

  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_pad
      wire sel = indicator_select_q[i];
      wire act = led_act[i];
      // open indicator: strap high means drive low while active
      wire led_out = led_push_pull ? act : ~led_pol_q[i];
      wire led_oe = led_push_pull | act;
      wire gp_out = buf_push_pull_q[i] & gp_data_out[i];
      wire gp_oe = gp_dir_out[i] &
                   (buf_push_pull_q[i] | ~gp_data_out[i]);
      assign pad_d.out[i] = sel ? led_out : gp_out;
      assign pad_d.oe[i] = sel ? led_oe : gp_oe;
      assign pad_d.pullup_en[i] = ~sel;
      assign pad_d.inbuf_en[i] = ~sel;
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pad_q <= '0;
    end
    else
    begin
      pad_q <= pad_d;
    end
  end

  assign pad = pad_q;
  assign system_irq_status = event_q;
  assign irq = irq_q;

  // checks
  property p_w1c_clear;
    @(posedge clk) disable iff (rst)
    wr_sts && wd[0] && !qual_hit[0] |=> !sts_q[0];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear)
    else $error("status bit not cleared by write one");

  property p_w0_keep;
    @(posedge clk) disable iff (rst)
    wr_sts && !wd[1] && sts_q[1] |=> sts_q[1];
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("status bit lost on write zero");

  property p_set_wins;
    @(posedge clk) disable iff (rst)
    qual_hit[0] |=> sts_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("qualified trigger did not set status");

  property p_irq_gate;
    @(posedge clk) disable iff (rst)
    irq |-> $past(global_en_q) && system_irq_status;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq without both enables");

  property p_irq_rise;
    @(posedge clk) disable iff (rst)
    (|(sts_q & en_q)) && global_en_q && !wr ##1 !wr |-> irq;
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("enabled pin event did not raise irq");

  property p_en_reset;
    @(posedge clk)
    rst |=> en_q == `PIM_RST_SIX && !global_en_q;
  endproperty
  a_en_reset: assert property (p_en_reset)
    else $error("enables not zero after reset");

  property p_led_no_pull;
    @(posedge clk) disable iff (rst)
    indicator_select_q[4] |=> !pad.pullup_en[4] && !pad.inbuf_en[4];
  endproperty
  a_led_no_pull: assert property (p_led_no_pull)
    else $error("indicator pin keeps pull-up or input buffer");

  property p_push_pull;
    @(posedge clk) disable iff (rst)
    indicator_select_q[5] && led_push_pull |=> pad.oe[5];
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull indicator not driven");

  property p_pol_hold;
    @(posedge clk) disable iff (rst)
    !rst ##1 !rst |-> $stable(led_pol_q);
  endproperty
  a_pol_hold: assert property (p_pol_hold)
    else $error("indicator polarity changed after reset");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
    setup && !apb_req.pwrite && hit_sts |=>
      apb_rsp.prdata[31:22] == 10'h000 && apb_rsp.prdata[15:6] == 10'h000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits read nonzero");

  property p_led_mode_no_trig;
    @(posedge clk) disable iff (rst)
    indicator_select_q[4] |-> !trig_level[4];
  endproperty
  a_led_mode_no_trig: assert property (p_led_mode_no_trig)
    else $error("indicator pin produced a trigger");

  property p_clear_vs_set;
    @(posedge clk) disable iff (rst)
    wr_sts && wd[1] && qual_hit[1] |=> sts_q[1];
  endproperty
  a_clear_vs_set: assert property (p_clear_vs_set)
    else $error("clearing write beat a present trigger");

  property p_gp_open_drain;
    @(posedge clk) disable iff (rst)
    !indicator_select_q[0] && gp_dir_out[0] && !buf_push_pull_q[0] &&
      gp_data_out[0] |=> !pad.oe[0] && !pad.out[0];
  endproperty
  a_gp_open_drain: assert property (p_gp_open_drain)
    else $error("open-drain pin driven while its data is one");

  property p_open_led_pol;
    @(posedge clk) disable iff (rst)
    indicator_select_q[4] && !led_push_pull && led_act[4] |=>
      pad.oe[4] && pad.out[4] != led_pol_q[4];
  endproperty
  a_open_led_pol: assert property (p_open_led_pol)
    else $error("open indicator drives the wrong level");
endmodule

//--- pim_pin_model.sv
// behavioural model of the lamps and signal sources on the six pins
module pim_pin_model (
  input wire logic clk,
  input wire pim_pkg::pim_pad_type pad,
  input wire logic [5:0] src_en,
  input wire logic [5:0] src_level,
  output logic [5:0] pin_level
);
  import pim_pkg::*;
  logic [5:0] float_q = 6'h00;
  logic [5:0] driven;
  logic [5:0] pulled;
  logic [5:0] floating;

  // a pin nobody holds toggles, so it never passes for a steady value
  always_ff @(posedge clk)
    float_q <= ~float_q;

  assign driven = pad.oe & pad.out;
  assign pulled = ~pad.oe & ~src_en & pad.pullup_en;
  assign floating = ~pad.oe & ~src_en & ~pad.pullup_en & float_q;
  assign pin_level = driven | (~pad.oe & src_en & src_level) | pulled |
                     floating;
endmodule

//--- pim_top_tb.sv
// self-checking bench for the pin interrupt and indicator block
module pim_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pim_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pim_apb_req_type req = '0;
  pim_apb_rsp_type rsp;
  logic [5:0] pin_in;
  pim_strap_type strap = '{led_pol: 6'h10, func: 2'h1, sel: 6'h30};
  pim_eeprom_type eep = '0;
  logic [5:0] gp_data = 6'h01;
  // no pin driven by the block while triggers are exercised
  logic [5:0] gp_dir = 6'h00;
  pim_led_src_type led_src = '0;
  pim_pad_type pad;
  logic sys_sts;
  logic irq;
  logic [5:0] src_en = 6'h3F;
  logic [5:0] src_lvl = 6'h3F;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  pim_top pim_top_inst (
    .clk(clk),
    .rst(rst),
    .apb_req(req),
    .apb_rsp(rsp),
    .pin_in(pin_in),
    .strap(strap),
    .eeprom(eep),
    .gp_data_out(gp_data),
    .gp_dir_out(gp_dir),
    .led_source(led_src),
    .pad(pad),
    .system_irq_status(sys_sts),
    .irq(irq)
  );

  pim_pin_model pim_pin_model_inst (
    .clk(clk),
    .pad(pad),
    .src_en(src_en),
    .src_level(src_lvl),
    .pin_level(pin_in)
  );

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD at %0t seen %08h expected %08h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do
      @(posedge clk);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic test_reset;
    apb(1'b0, 12'h1BC, '0);
    check(rd, 32'h0000_0130);
    apb(1'b0, 12'h1E8, '0);
    check(rd, 32'h0000_0000);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    check(err, 1'b1);
    apb(1'b0, 12'h100, '0);
    check(rd, 32'h0000_0000);
    $display("reset values done");
  endtask

  task automatic test_irq;
    tick(1);
    src_lvl[0] <= 1'b0;
    tick(12);
    src_lvl[0] <= 1'b1;
    apb(1'b0, 12'h1E8, '0);
    check(rd, 32'h0000_0001);
    @(negedge clk);
    check(sys_sts, 1'b0);
    apb(1'b1, 12'h1E8, 32'hFFC1_FFC0);
    apb(1'b0, 12'h1E8, '0);
    check(rd, 32'h0001_0001);
    @(negedge clk);
    check(sys_sts, 1'b1);
    check(irq, 1'b0);
    apb(1'b1, 12'h05C, 32'h0000_1000);
    tick(2);
    @(negedge clk);
    check(irq, 1'b1);
    apb(1'b1, 12'h1E8, 32'h0001_0001);
    apb(1'b0, 12'h1E8, '0);
    check(rd, 32'h0001_0000);
    @(negedge clk);
    check(irq, 1'b0);
    tick(1);
    src_lvl[2] <= 1'b0;
    tick(1);
    // one cycle is shorter than the minimum active time
    src_lvl[2] <= 1'b1;
    tick(8);
    apb(1'b0, 12'h1E8, '0);
    check(rd, 32'h0001_0000);
    apb(1'b1, 12'h1E0, 32'h0002_0000);
    tick(10);
    apb(1'b0, 12'h1E8, '0);
    check(rd, 32'h0001_0002);
    apb(1'b1, 12'h1E8, 32'h0001_0002);
    apb(1'b0, 12'h1E8, '0);
    check(rd, 32'h0001_0002);
    apb(1'b1, 12'h1E0, 32'h0000_0000);
    tick(4);
    apb(1'b1, 12'h1E8, 32'h0001_003F);
    apb(1'b0, 12'h1E8, '0);
    check(rd, 32'h0001_0000);
    $display("pin interrupt done");
  endtask

  task automatic test_pads;
    tick(1);
    led_src[1] <= 6'h10;
    led_src[3] <= 6'h20;
    gp_dir <= 6'h03;
    tick(3);
    @(negedge clk);
    check(pad.oe, 6'h12);
    check(pad.out & 6'h13, 6'h00);
    check(pad.pullup_en, 6'h0F);
    check(pad.inbuf_en, 6'h0F);
    apb(1'b1, 12'h1BC, 32'hFFFF_FF30);
    apb(1'b1, 12'h1E0, 32'h0000_0001);
    apb(1'b0, 12'h1BC, '0);
    check(rd, 32'h0000_0330);
    @(negedge clk);
    check(pad.oe, 6'h33);
    check(pad.out & 6'h33, 6'h21);
    $display("pad modes done");
  endtask

  task automatic test_eeprom;
    tick(1);
    led_src[0] <= 6'h10;
    eep <= '{load: 1'b1, func: 2'h0, sel: 6'h10};
    tick(1);
    eep.load <= 1'b0;
    apb(1'b0, 12'h1BC, '0);
    check(rd, 32'h0000_0010);
    @(negedge clk);
    check(pad.oe[5:4], 2'h1);
    check(pad.out[4], 1'b0);
    $display("loader override done");
  endtask

  // a hang ends in the same closing report
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_irq();
    test_pads();
    test_eeprom();
    complete_run();
  end
endmodule
